//--- hdl/sadet_pkg.sv
// Purpose: Shared constants and helpers for the serial audio receiver
// Assumes: System clock at 40 MHz
// Notes: Formats and word lengths arrive on plain pins
package sadet_pkg;
  // ****************************************
  // Constants
  // ****************************************
  localparam int SYS_CLK_MHZ = 40;
  localparam int SAMPLE_W = 24;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_RJ = 2'h2;
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_20 = 2'h1;
  localparam logic [4:0] WBITS_16 = 5'h10;
  localparam logic [4:0] WBITS_20 = 5'h14;
  localparam logic [4:0] WBITS_24 = 5'h18;
  localparam logic [6:0] BPF_32 = 7'h20;
  localparam logic [6:0] BPF_48 = 7'h30;
  localparam logic [6:0] BPF_64 = 7'h40;
  localparam logic [1:0] RATIO_NONE = 2'h0;
  localparam logic [1:0] RATIO_32 = 2'h1;
  localparam logic [1:0] RATIO_48 = 2'h2;
  localparam logic [1:0] RATIO_64 = 2'h3;
  localparam int MCLK_LOSS_NS = 1000;
  localparam int MCLK_LOSS_CYC = (MCLK_LOSS_NS * SYS_CLK_MHZ) / 1000;
  localparam int FRAME_LOSS_US = 250;
  localparam int RAMP_STEP_NS = 1600;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [2:0] STABLE_FRAMES = 3'h4;
  localparam logic [9:0] MCLK_TOL = 10'h001;
  localparam logic [9:0] MCLK_SAT = 10'h3FF;
  localparam logic [9:0] MCLK_RATIOS [6] = '{10'h040, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200};
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [7:0] GAIN_FULL = 8'hFF;

  typedef enum logic [1:0] {ST_LIMP, ST_DETECT, ST_RUN} sadet_state_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] sadet_wlen_bits(input logic [1:0] w);
    if (w == WLEN_16) begin
      return WBITS_16;
    end else if (w == WLEN_20) begin
      return WBITS_20;
    end
    return WBITS_24;
  endfunction : sadet_wlen_bits
endpackage : sadet_pkg

//--- hdl/sadet_link_if.sv
// Purpose: Carries finished sample pairs from the bit clock domain
// Assumes: Data stands for at least half a frame after each toggle
// Notes: Toggle is the only signal that needs synchronising
`timescale 1ns/1ps
interface sadet_link_if;
  logic pair_tgl;
  logic [23:0] left;
  logic [23:0] right;
  logic [6:0] frame_bits;
  modport rx (output pair_tgl, output left, output right, output frame_bits);
  modport sys (input pair_tgl, input left, input right, input frame_bits);
endinterface : sadet_link_if

//--- hdl/sadet_link_rx.sv
// Purpose: Bit clock side deframer for I2S, left and right justified
// Assumes: Frame clock and data change away from the rising bit clock edge
// Notes: Words leave MSB aligned in 24 bits
`timescale 1ns/1ps
module sadet_link_rx import sadet_pkg::*; (
  input wire logic i_bclk,
  input wire logic i_rst,
  input wire logic i_lrclk,
  input wire logic i_serial_audio_in,
  input wire logic [1:0] i_fmt,
  input wire logic [1:0] i_wlen,
  sadet_link_if.rx lnk
);
  logic rst_s1_q, rst_q, lr1_q, lr2_q, lr3_q, sd1_q;
  logic [1:0] fmt_s1_q, fmt_q, wlen_s1_q, wlen_q;
  logic [6:0] pos_q, len_l_q;
  logic [23:0] word_q, hist_q, done_word;
  logic i2s, m_cur, m_prev, d, bnd, slot_left;
  logic [4:0] nbits;

  // ****************************************
  // Crossings and pin sampling
  // ****************************************
  always_ff @(posedge i_bclk) begin
    rst_s1_q <= i_rst;
    rst_q <= rst_s1_q;
    fmt_s1_q <= i_fmt;
    fmt_q <= fmt_s1_q;
    wlen_s1_q <= i_wlen;
    wlen_q <= wlen_s1_q;
  end

  always_ff @(posedge i_bclk) begin // [RULE10]
    lr1_q <= i_lrclk;
    lr2_q <= lr1_q;
    lr3_q <= lr2_q;
    sd1_q <= i_serial_audio_in;
  end

  // ****************************************
  // Slot tracking
  // ****************************************
  assign i2s = (fmt_q == FMT_I2S);
  assign m_cur = i2s ? lr2_q : lr1_q; // [RULE9] [RULE13]
  assign m_prev = i2s ? lr3_q : lr2_q;
  assign d = sd1_q; // [RULE9]
  assign bnd = (m_cur != m_prev);
  assign slot_left = i2s ? ~m_prev : m_prev; // [RULE8] [RULE12]
  assign nbits = sadet_wlen_bits(wlen_q); // [RULE7]
  assign done_word = (fmt_q == FMT_RJ) ? (hist_q << (5'd24 - nbits)) : word_q; // [RULE14] [RULE15]

  always_ff @(posedge i_bclk) begin
    if (rst_q) begin
      pos_q <= 7'h00;
    end else if (bnd) begin
      pos_q <= 7'h01;
    end else if (pos_q != 7'h7F) begin
      pos_q <= pos_q + 7'h01;
    end
  end

  always_ff @(posedge i_bclk) begin // [RULE10]
    hist_q <= {hist_q[22:0], d};
    if (bnd) begin
      word_q <= {d, 23'h000000};
    end else if (pos_q < {2'h0, nbits}) begin // [RULE11]
      word_q[5'd23 - pos_q[4:0]] <= d;
    end
  end

  // ****************************************
  // Pair hand-off
  // ****************************************
  always_ff @(posedge i_bclk) begin // [RULE17]
    if (rst_q) begin
      lnk.pair_tgl <= 1'b0;
      lnk.left <= 24'h000000;
      lnk.right <= 24'h000000;
      lnk.frame_bits <= 7'h00;
      len_l_q <= 7'h00;
    end else if (bnd && slot_left) begin
      lnk.left <= done_word;
      len_l_q <= pos_q;
    end else if (bnd) begin
      lnk.right <= done_word;
      lnk.frame_bits <= 7'(len_l_q + pos_q);
      lnk.pair_tgl <= ~lnk.pair_tgl;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_lj_msb;
    @(posedge i_bclk) disable iff (rst_q)
    (bnd && fmt_q == FMT_LJ) |=> word_q[23] == $past(sd1_q);
  endproperty
  a_lj_msb: assert property (p_lj_msb) else $error("LJ MSB not taken at toggle"); // [RULE13]

  property p_rj_lsb;
    @(posedge i_bclk) disable iff (rst_q)
    (bnd && !slot_left && fmt_q == FMT_RJ) |=> lnk.right[5'd24 - nbits] == $past(hist_q[0]);
  endproperty
  a_rj_lsb: assert property (p_rj_lsb) else $error("RJ LSB misplaced"); // [RULE14]

  property p_pair_tgl;
    @(posedge i_bclk) disable iff (rst_q)
    (bnd && !slot_left) |=> lnk.pair_tgl != $past(lnk.pair_tgl) ##1 lnk.pair_tgl == $past(lnk.pair_tgl);
  endproperty
  a_pair_tgl: assert property (p_pair_tgl) else $error("Pair toggle not single"); // [RULE17]
endmodule : sadet_link_rx

//--- hdl/sadet_top.sv
// Purpose: Serial audio input with clock rate detection and error muting
// Assumes: System clock is the trimmed oscillator; bit clock is a separate domain
// Notes: Gain output is applied downstream; samples are MSB aligned
//
// Functional notes
// [RULE1] Bit clock must be 32, 48 or 64 fs
// [RULE2] Source gives one frame clock period per sample
// [RULE3] Processing clock from master clock or oscillator
// [RULE4] Detect sample and master rates without help
// [RULE5] Clock error mutes at once, limp mode
// [RULE6] Hard unmute by default, soft ramp selectable
// [RULE7] Accept 16, 20 or 24 bit words
// [RULE8] I2S: frame clock low is left
// [RULE9] I2S: data starts one bit late
// [RULE10] MSB first, captured on rising bit clock
// [RULE11] I2S and LJ ignore trailing bits
// [RULE12] LJ and RJ: frame clock high is left
// [RULE13] LJ: MSB in the toggle period
// [RULE14] RJ: LSB in last period before toggle
// [RULE15] RJ ignores leading unused bits
// [RULE16] Samples are two's complement
// [RULE17] Deliver one left/right pair per frame
`timescale 1ns/1ps
module sadet_top import sadet_pkg::*; #(
  parameter int FRAME_LOSS_CYC = FRAME_LOSS_US * SYS_CLK_MHZ
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_MCLK,
  input wire logic I_BCLK,
  input wire logic I_LRCLK,
  input wire logic I_SERIAL_AUDIO_IN,
  input wire logic [1:0] I_FMT,
  input wire logic [1:0] I_WLEN,
  input wire logic I_SOFT_UNMUTE,
  output logic [23:0] O_LEFT,
  output logic [23:0] O_RIGHT,
  output logic O_SAMPLE_VALID,
  output logic O_MUTE,
  output logic [7:0] O_GAIN,
  output logic O_LIMP,
  output logic O_INTERNAL_PROCESSING_CLK,
  output logic O_PROC_SRC_MCLK,
  output logic [1:0] O_BCLK_RATIO,
  output logic [9:0] O_MCLK_PER_FS
);
  // ****************************************
  // Declarations
  // ****************************************
  sadet_link_if lnk ();

  sadet_state_t state_q;
  logic pt_s1_q, pt_s2_q, pt_s3_q;
  logic mk_s1_q, mk_s2_q, mk_s3_q;
  logic su_s1_q, soft_q;
  logic frame_ev, mclk_rise, mclk_lost, frame_lost;
  logic frame_good, err;
  logic [5:0] mclk_gap_q;
  logic [13:0] frame_gap_q;
  logic [9:0] mclk_cnt_q, mratio_q;
  logic [6:0] bits_q;
  logic [2:0] good_cnt_q;
  logic [6:0] ramp_cnt_q;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic near(input logic [9:0] a, input logic [9:0] b);
    logic [9:0] diff;
    diff = (a > b) ? 10'(a - b) : 10'(b - a);
    return diff <= MCLK_TOL;
  endfunction : near

  function automatic logic mclk_ok(input logic [9:0] cnt);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 6; i++) begin
      hit = hit | near(cnt, MCLK_RATIOS[i]);
    end
    return hit;
  endfunction : mclk_ok

  function automatic logic [1:0] bpf_code(input logic [6:0] b);
    if (b == BPF_32) begin
      return RATIO_32;
    end else if (b == BPF_48) begin
      return RATIO_48;
    end else if (b == BPF_64) begin
      return RATIO_64;
    end
    return RATIO_NONE;
  endfunction : bpf_code

  // ****************************************
  // Bit clock domain receiver
  // ****************************************
  sadet_link_rx u_link_rx (
    .i_bclk(I_BCLK),
    .i_rst(I_RST),
    .i_lrclk(I_LRCLK),
    .i_serial_audio_in(I_SERIAL_AUDIO_IN),
    .i_fmt(I_FMT),
    .i_wlen(I_WLEN),
    .lnk(lnk.rx)
  );

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    pt_s1_q <= lnk.pair_tgl;
    pt_s2_q <= pt_s1_q;
    pt_s3_q <= pt_s2_q;
    mk_s1_q <= I_MCLK;
    mk_s2_q <= mk_s1_q;
    mk_s3_q <= mk_s2_q;
    su_s1_q <= I_SOFT_UNMUTE;
    soft_q <= su_s1_q;
  end

  assign frame_ev = pt_s2_q ^ pt_s3_q;
  assign mclk_rise = mk_s2_q & ~mk_s3_q;

  // ****************************************
  // Clock monitors
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      mclk_gap_q <= 6'(MCLK_LOSS_CYC);
    end else if (mclk_rise) begin
      mclk_gap_q <= 6'h00;
    end else if (mclk_gap_q != 6'(MCLK_LOSS_CYC)) begin
      mclk_gap_q <= mclk_gap_q + 6'h01;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      frame_gap_q <= 14'(FRAME_LOSS_CYC);
    end else if (frame_ev) begin
      frame_gap_q <= 14'h0000;
    end else if (frame_gap_q != 14'(FRAME_LOSS_CYC)) begin
      frame_gap_q <= frame_gap_q + 14'h0001;
    end
  end

  assign mclk_lost = (mclk_gap_q == 6'(MCLK_LOSS_CYC));
  assign frame_lost = (frame_gap_q == 14'(FRAME_LOSS_CYC));

  always_ff @(posedge I_SYS_CLK) begin // [RULE4]
    if (I_RST) begin
      mclk_cnt_q <= 10'h000;
    end else if (frame_ev) begin
      mclk_cnt_q <= mclk_rise ? 10'h001 : 10'h000;
    end else if (mclk_rise && mclk_cnt_q != MCLK_SAT) begin
      mclk_cnt_q <= mclk_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin // [RULE4]
    if (I_RST) begin
      mratio_q <= 10'h000;
      bits_q <= 7'h00;
    end else if (frame_ev) begin
      mratio_q <= mclk_cnt_q;
      bits_q <= lnk.frame_bits;
    end
  end

  // A frame is good when its ratios are legal and match the previous frame
  assign frame_good = (bpf_code(lnk.frame_bits) != RATIO_NONE) && mclk_ok(mclk_cnt_q) &&
                      near(mclk_cnt_q, mratio_q) && (lnk.frame_bits == bits_q); // [RULE1] [RULE4]
  assign err = mclk_lost | frame_lost | (frame_ev & ~frame_good); // [RULE5]

  // ****************************************
  // Lock state machine
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin // [RULE4] [RULE5]
    if (I_RST) begin
      state_q <= ST_LIMP;
    end else begin
      case (state_q)
        ST_LIMP: begin
          if (!mclk_lost) begin
            state_q <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (err) begin
            state_q <= ST_LIMP;
          end else if (frame_ev && good_cnt_q == 3'(STABLE_FRAMES - 3'h1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (err) begin
            state_q <= ST_LIMP;
          end
        end
        default: begin
          state_q <= ST_LIMP;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin // [RULE4]
    if (I_RST || state_q != ST_DETECT || err) begin
      good_cnt_q <= 3'h0;
    end else if (frame_ev) begin
      good_cnt_q <= good_cnt_q + 3'h1;
    end
  end

  // ****************************************
  // Mute and volume restore
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin // [RULE6]
    if (I_RST || state_q != ST_RUN || err || O_GAIN == GAIN_FULL) begin
      ramp_cnt_q <= 7'h00;
    end else if (ramp_cnt_q == 7'(RAMP_STEP_CYC - 1)) begin
      ramp_cnt_q <= 7'h00;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_GAIN <= GAIN_MUTE;
      O_MUTE <= 1'b1;
    end else if (state_q != ST_RUN || err) begin
      O_GAIN <= GAIN_MUTE; // [RULE5]
      O_MUTE <= 1'b1;
    end else begin
      O_MUTE <= 1'b0;
      if (!soft_q) begin
        O_GAIN <= GAIN_FULL; // [RULE6]
      end else if (O_GAIN != GAIN_FULL && ramp_cnt_q == 7'(RAMP_STEP_CYC - 1)) begin
        O_GAIN <= O_GAIN + 8'h01; // [RULE6]
      end
    end
  end

  // ****************************************
  // Processing clock source
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin // [RULE3]
    if (I_RST) begin
      O_PROC_SRC_MCLK <= 1'b0;
      O_LIMP <= 1'b1;
      O_INTERNAL_PROCESSING_CLK <= 1'b0;
    end else begin
      O_PROC_SRC_MCLK <= (state_q == ST_RUN) && !err;
      O_LIMP <= (state_q != ST_RUN) || err;
      if (!O_PROC_SRC_MCLK || mclk_rise) begin
        O_INTERNAL_PROCESSING_CLK <= ~O_INTERNAL_PROCESSING_CLK;
      end
    end
  end

  // ****************************************
  // Detected rates
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin // [RULE1] [RULE4]
    if (I_RST || state_q != ST_RUN) begin
      O_BCLK_RATIO <= RATIO_NONE;
      O_MCLK_PER_FS <= 10'h000;
    end else begin
      O_BCLK_RATIO <= bpf_code(bits_q);
      O_MCLK_PER_FS <= mratio_q;
    end
  end

  // ****************************************
  // Sample delivery
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin // [RULE17]
    if (I_RST) begin
      O_LEFT <= 24'h000000;
      O_RIGHT <= 24'h000000;
      O_SAMPLE_VALID <= 1'b0;
    end else if (frame_ev && frame_good && state_q == ST_RUN && !mclk_lost) begin
      O_LEFT <= lnk.left; // [RULE16]
      O_RIGHT <= lnk.right;
      O_SAMPLE_VALID <= 1'b1;
    end else if (state_q != ST_RUN) begin
      O_LEFT <= 24'h000000;
      O_RIGHT <= 24'h000000;
      O_SAMPLE_VALID <= 1'b0;
    end else begin
      O_SAMPLE_VALID <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_err_mute;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q == ST_RUN && err) |=> (O_GAIN == GAIN_MUTE && O_MUTE && state_q == ST_LIMP);
  endproperty
  a_err_mute: assert property (p_err_mute) else $error("Clock error did not mute"); // [RULE5]

  property p_hard_unmute;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q == ST_RUN && !err && !soft_q) |=> O_GAIN == GAIN_FULL;
  endproperty
  a_hard_unmute: assert property (p_hard_unmute) else $error("Hard unmute not single step"); // [RULE6]

  property p_soft_step;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q == ST_RUN && soft_q && O_GAIN != GAIN_FULL && $past(soft_q)) |->
      (O_GAIN == $past(O_GAIN) || O_GAIN == $past(O_GAIN) + 8'h01);
  endproperty
  a_soft_step: assert property (p_soft_step) else $error("Soft ramp jumped"); // [RULE6]

  property p_legal_ratio;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q == ST_RUN) |-> (bits_q == BPF_32 || bits_q == BPF_48 || bits_q == BPF_64);
  endproperty
  a_legal_ratio: assert property (p_legal_ratio) else $error("Running on illegal bit clock ratio"); // [RULE1]

  property p_osc_clock;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (!O_PROC_SRC_MCLK ##1 !O_PROC_SRC_MCLK) |-> O_INTERNAL_PROCESSING_CLK != $past(O_INTERNAL_PROCESSING_CLK);
  endproperty
  a_osc_clock: assert property (p_osc_clock) else $error("Oscillator clock not running"); // [RULE3]

  property p_lock;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q == ST_DETECT && !err && frame_ev && good_cnt_q == 3'(STABLE_FRAMES - 3'h1)) |=>
      state_q == ST_RUN ##1 !O_LIMP;
  endproperty
  a_lock: assert property (p_lock) else $error("Lock not taken after stable frames"); // [RULE4]

  property p_one_pair;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    O_SAMPLE_VALID |=> !O_SAMPLE_VALID [*8];
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("Pairs delivered too often"); // [RULE17]

  property p_muted_silent;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (state_q != ST_RUN) |=> (!O_SAMPLE_VALID && O_LEFT == 24'h000000 && O_MUTE);
  endproperty
  a_muted_silent: assert property (p_muted_silent) else $error("Samples leaked while muted"); // [RULE5]
endmodule : sadet_top

//--- verif/sadet_src_model.sv
// Purpose: Audio source model driving master, bit and frame clocks and data
// Assumes: Bit clock 30 ns, master clock 100 ns, frame period 6.4 us
// Notes: Bit clock stands low between frames so master count stays 64
`timescale 1ns/1ps
module sadet_src_model import sadet_pkg::*; (
  input wire logic [1:0] i_fmt,
  input wire logic [4:0] i_wbits,
  input wire logic [6:0] i_nbits,
  input wire logic i_mclk_en,
  output logic o_mclk,
  output logic o_bclk,
  output logic o_lrclk,
  output logic o_data
);
  logic [47:0] sq[$];
  int frames;

  task automatic push(input logic [47:0] pair);
    sq.push_back(pair);
  endtask : push

  initial begin
    o_mclk = 1'b0;
    forever begin
      #50;
      o_mclk = i_mclk_en ? ~o_mclk : 1'b0;
    end
  end

  initial begin
    logic [47:0] pr;
    logic [23:0] wd;
    logic [1:0] fmt;
    logic last;
    int nb;
    int w;
    int st;
    int idx;
    frames = 0;
    last = 1'b0;
    o_bclk = 1'b0;
    o_lrclk = 1'b0;
    o_data = 1'b0;
    #1;
    forever begin
      fmt = i_fmt;
      nb = int'(i_nbits);
      w = int'(i_wbits);
      pr = (sq.size() > 0) ? sq.pop_front() : 48'h000000000000;
      for (int c = 0; c < 2; c++) begin
        wd = (c == 1) ? pr[23:0] : pr[47:24];
        st = (fmt == FMT_I2S) ? 1 : (fmt == FMT_RJ) ? nb / 2 - w : 0;
        for (int p = 0; p < nb / 2; p++) begin
          o_bclk = 1'b0;
          o_lrclk = (fmt == FMT_I2S) ? c[0] : ~c[0];
          idx = p - st;
          o_data = (idx >= 0 && idx < w) ? wd[23 - idx] : (fmt == FMT_I2S && p == 0) ? last : p[0] ^ c[0];
          #15 o_bclk = 1'b1;
          #15;
        end
        last = wd[24 - w];
      end
      o_bclk = 1'b0;
      #(6400 - nb * 30);
      frames++;
    end
  end
endmodule : sadet_src_model

//--- verif/tb.sv
// Purpose: Self-checking bench for the serial audio receiver
// Assumes: Source model streams frames continuously, zero pairs when idle
// Notes: Frame loss limit shortened to 600 cycles
`timescale 1ns/1ps
module tb import sadet_pkg::*;;
  logic sys_clk, rst, mclk, bclk, lrclk, serial_audio_in, soft_unmute, mclk_en;
  logic [1:0] fmt, wlen, ratio;
  logic [4:0] wbits;
  logic [6:0] nbits;
  logic [23:0] left, right;
  logic valid, mute, limp, pclk, src_mclk;
  logic [7:0] gain, unmute_gain;
  logic [9:0] mclk_per_fs;
  logic [47:0] rxq[$];
  int num_errors = 0;
  int compares = 0;

  sadet_top #(.FRAME_LOSS_CYC(600)) u_sadet_top (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_MCLK(mclk), .I_BCLK(bclk),
    .I_LRCLK(lrclk), .I_SERIAL_AUDIO_IN(serial_audio_in), .I_FMT(fmt), .I_WLEN(wlen), .I_SOFT_UNMUTE(soft_unmute),
    .O_LEFT(left), .O_RIGHT(right), .O_SAMPLE_VALID(valid), .O_MUTE(mute), .O_GAIN(gain), .O_LIMP(limp),
    .O_INTERNAL_PROCESSING_CLK(pclk), .O_PROC_SRC_MCLK(src_mclk), .O_BCLK_RATIO(ratio), .O_MCLK_PER_FS(mclk_per_fs));
  sadet_src_model u_sadet_src_model (.i_fmt(fmt), .i_wbits(wbits), .i_nbits(nbits), .i_mclk_en(mclk_en),
    .o_mclk(mclk), .o_bclk(bclk), .o_lrclk(lrclk), .o_data(serial_audio_in));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (valid === 1'b1) begin
      rxq.push_back({left, right});
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic timed_out(input string what);
    num_errors++;
    $display("[ERR] %s expected done seen timeout", what);
    end_sim();
  endtask : timed_out

  task automatic wait_frames(input int n);
    int f0;
    f0 = u_sadet_src_model.frames;
    for (int i = 0; i < n * 300; i++) begin
      @(negedge sys_clk);
      if (u_sadet_src_model.frames >= f0 + n) return;
    end
    timed_out("frames");
  endtask : wait_frames

  task automatic settle();
    wait_frames(3);
    for (int i = 0; i < 12000; i++) begin
      @(posedge sys_clk);
      #1;
      if (mute === 1'b0) begin
        unmute_gain = gain;
        wait_frames(1);
        return;
      end
    end
    timed_out("relock");
  endtask : settle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_lock();
    settle();
    check("ratio", 48'(ratio), 48'(RATIO_64));
    check("mclk_fs", 48'(mclk_per_fs >= 10'h03F && mclk_per_fs <= 10'h041), 48'h1);
    check("src_mclk", 48'({src_mclk, limp}), 48'h2);
    check("hard_gain", 48'(unmute_gain), 48'(GAIN_FULL));
    $display("test lock done");
  endtask : t_lock

  task automatic t_data(input logic [1:0] f, input logic [1:0] wl, input logic [6:0] nb, input logic [1:0] rt);
    logic [47:0] smp [3];
    logic [23:0] msk;
    int k;
    smp = '{48'h8000017F00FE, 48'h5A5A5AA5A5A5, 48'hC3C3C33C3C3C};
    @(negedge sys_clk);
    fmt = f;
    wlen = wl;
    wbits = (wl == WLEN_16) ? WBITS_16 : (wl == WLEN_20) ? WBITS_20 : WBITS_24;
    nbits = nb;
    settle();
    check("ratio", 48'(ratio), 48'(rt));
    msk = 24'hFFFFFF << (24 - int'(wbits));
    rxq.delete();
    for (int i = 0; i < 3; i++) u_sadet_src_model.push(smp[i]);
    wait_frames(5);
    k = 0;
    while (k < rxq.size() && rxq[k] === 48'h000000000000) k++;
    for (int i = 0; i < 3; i++) begin
      check("pair", rxq[k + i], {smp[i][47:24] & msk, smp[i][23:0] & msk});
    end
    $display("test data fmt %0d wlen %0d bits %0d done", f, wl, nb);
  endtask : t_data

  task automatic t_bad_ratio();
    @(negedge sys_clk);
    nbits = 7'h28;
    wait_frames(2);
    rxq.delete();
    wait_frames(6);
    check("bad_mute", 48'({mute, limp}), 48'h3);
    check("bad_pairs", 48'(rxq.size()), 48'h0);
    @(negedge sys_clk);
    nbits = BPF_64;
    settle();
    $display("test bad ratio done");
  endtask : t_bad_ratio

  task automatic t_loss();
    int i;
    logic [7:0] g0;
    logic pc;
    @(negedge sys_clk);
    soft_unmute = 1'b1;
    mclk_en = 1'b0;
    for (i = 0; i < 100 && mute !== 1'b1; i++) @(negedge sys_clk);
    if (i == 100) timed_out("mute");
    check("loss_state", 48'({gain, limp, src_mclk}), 48'h002);
    pc = pclk;
    @(negedge sys_clk);
    check("limp_clk", 48'(pclk ^ pc), 48'h1);
    mclk_en = 1'b1;
    settle();
    check("soft_start", 48'(unmute_gain < 8'h02), 48'h1);
    g0 = gain;
    repeat (640) @(negedge sys_clk);
    check("soft_ramp", 48'(gain >= g0 + 8'h09 && gain <= g0 + 8'h0B), 48'h1);
    $display("test clock loss done");
  endtask : t_loss

  initial begin
    rst = 1'b1;
    fmt = FMT_LJ;
    wlen = 2'h2;
    wbits = WBITS_24;
    nbits = BPF_64;
    soft_unmute = 1'b0;
    mclk_en = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(posedge sys_clk);
    #1;
    check("reset_state", 48'({mute, limp, gain, valid, src_mclk}), 48'hC00);
    t_lock();
    t_data(FMT_LJ, 2'h2, BPF_64, RATIO_64);
    t_data(FMT_LJ, WLEN_20, BPF_48, RATIO_48);
    t_data(FMT_I2S, 2'h2, BPF_64, RATIO_64);
    t_data(FMT_I2S, WLEN_16, BPF_32, RATIO_32);
    t_data(FMT_I2S, 2'h2, BPF_48, RATIO_48);
    t_data(FMT_RJ, 2'h2, BPF_64, RATIO_64);
    t_data(FMT_RJ, WLEN_20, BPF_48, RATIO_48);
    t_data(FMT_RJ, WLEN_16, BPF_32, RATIO_32);
    t_bad_ratio();
    t_loss();
    end_sim();
  end
endmodule : tb
